// ---- hdl/bq4_sram_dev.sv ----
// sram end: samples link pins, burst-of-four ddr write and read ports
// Behaviour
// - write data captured on both input clocks
// - low write select on true edge starts write
// - deselected write port changes no memory
// - byte masks sampled with their data beat
// - masked-off byte keeps stored value
// - mask bit n governs nine-bit lane n
// - address sampled on true input clock rise
// - one array; address selects one burst
// - address ignored when slot select inactive
// - read words launched on output clock pair, on input clock pair in single-clock mode
// - deselected read port output is undriven
// - low read select on true edge starts read
// - finish pending burst, release after next edge
// - each read returns four sequential words
// - controller supplies output clock pair
// - read and write addresses alternate slots
// - each location holds four sequential words
// - accesses start only on true input rise
`timescale 1ns/1ns
`default_nettype none
module bq4_sram_dev
    import bq4_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // memory pins
    bq4_link_if.device_mp link,
    // status
    output logic write_commit,
    output logic read_launch
);
    import bq4_pkg::*;

    typedef struct packed {
        bq4_pins_s sync1;
        bq4_pins_s sync2;
        logic [3:0] clk_prev;
        logic slot_wr;
        bq4_wr_e wr_state;
        logic [BEAT_W-1:0] wr_beat;
        logic [ADDR_W-1:0] wr_addr;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_pend_addr;
        bq4_rd_e rd_state;
        logic [BEAT_W-1:0] rd_beat;
        logic [ADDR_W-1:0] rd_addr;
        logic [WORD_W-1:0] q;
        logic commit;
        logic launch;
        logic [STORE_WORDS-1:0][WORD_W-1:0] mem;
    } bq4_dev_s;

    // idle pin levels in the syncs, so no false edge follows reset
    localparam bq4_dev_s DEV_RST = '{
        sync1: RST_PINS,
        sync2: RST_PINS,
        clk_prev: RST_CLK_PREV,
        slot_wr: RST_SLOT_WR,
        wr_state: WR_IDLE,
        rd_state: RD_OFF,
        default: '0
    };

    bq4_dev_s r;
    bq4_dev_s next_r;
    bq4_pins_s pins;
    logic k_rise;
    logic kc_rise;
    logic c_rise;
    logic cc_rise;
    logic out_true;
    logic out_comp;

    // word position inside the flip-flop store
    function automatic logic [STORE_AW+BEAT_W-1:0] store_index(
        input logic [ADDR_W-1:0] addr,
        input logic [BEAT_W-1:0] beat
    );
        store_index = {addr[STORE_AW-1:0], beat};
    endfunction

    // keep each nine-bit lane whose mask is high
    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] old_word,
        input logic [WORD_W-1:0] new_word,
        input logic [MASK_W-1:0] mask_n
    );
        logic [WORD_W-1:0] res;
        res = old_word;
        for (int i = 0; i < MASK_W; i++)
        begin
            if (!mask_n[i])
            begin
                res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
        lane_merge = res;
    endfunction

    assign pins = '{
        k: link.input_timing_true,
        kc: link.input_timing_comp,
        c: link.output_timing_true,
        cc: link.output_timing_comp,
        mode: link.single_clock_mode,
        rps_n: link.read_port_select_n,
        wps_n: link.write_port_select_n,
        addr: link.shared_addr,
        wdata: link.write_value_in,
        mask_n: link.byte_lane_mask_n
    };

    // edges of the sampled link clocks
    assign k_rise = r.sync2.k & ~r.clk_prev[3];
    assign kc_rise = r.sync2.kc & ~r.clk_prev[2];
    assign c_rise = r.sync2.c & ~r.clk_prev[1];
    assign cc_rise = r.sync2.cc & ~r.clk_prev[0];
    assign out_true = r.sync2.mode ? k_rise : c_rise;
    assign out_comp = r.sync2.mode ? kc_rise : cc_rise;

    always_comb
    begin
        next_r = r;
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        next_r.clk_prev = {r.sync2.k, r.sync2.kc, r.sync2.c, r.sync2.cc};
        next_r.commit = 1'b0;
        next_r.launch = 1'b0;

        // slots alternate on every true input rise, read slot first
        if (k_rise)
        begin
            next_r.slot_wr = ~r.slot_wr;
        end

        // write port: beats 1..3 on the following input edges
        if (r.wr_state == WR_BURST && (k_rise || kc_rise))
        begin
            next_r.mem[store_index(r.wr_addr, r.wr_beat)] =
                lane_merge(r.mem[store_index(r.wr_addr, r.wr_beat)],
                           r.sync2.wdata, r.sync2.mask_n);
            next_r.wr_beat = r.wr_beat + 2'h1;
            if (r.wr_beat == 2'h3)
            begin
                next_r.wr_state = WR_IDLE;
                next_r.commit = 1'b1;
            end
        end
        else if (k_rise && r.slot_wr && !r.sync2.wps_n)
        begin
            next_r.wr_addr = r.sync2.addr;
            next_r.mem[store_index(r.sync2.addr, 2'h0)] =
                lane_merge(r.mem[store_index(r.sync2.addr, 2'h0)],
                           r.sync2.wdata, r.sync2.mask_n);
            next_r.wr_beat = 2'h1;
            next_r.wr_state = WR_BURST;
        end

        // read port: true output edge launches even beats or releases
        if (out_true)
        begin
            if (r.rd_state == RD_BURST && r.rd_beat == 2'h2)
            begin
                next_r.q = r.mem[store_index(r.rd_addr, r.rd_beat)];
                next_r.rd_beat = r.rd_beat + 2'h1;
                next_r.launch = 1'b1;
            end
            else if (r.rd_pend)
            begin
                next_r.rd_pend = 1'b0;
                next_r.rd_addr = r.rd_pend_addr;
                next_r.q = r.mem[store_index(r.rd_pend_addr, 2'h0)];
                next_r.rd_beat = 2'h1;
                next_r.rd_state = RD_BURST;
                next_r.launch = 1'b1;
            end
            else if (r.rd_state == RD_TAIL)
            begin
                next_r.rd_state = RD_OFF;
            end
        end

        // complementary output edge launches odd beats
        if (out_comp && r.rd_state == RD_BURST && r.rd_beat[0])
        begin
            next_r.q = r.mem[store_index(r.rd_addr, r.rd_beat)];
            next_r.rd_beat = r.rd_beat + 2'h1;
            next_r.launch = 1'b1;
            if (r.rd_beat == 2'h3)
            begin
                next_r.rd_state = RD_TAIL;
            end
        end

        // read start is queued until the next true output edge
        if (k_rise && !r.slot_wr && !r.sync2.rps_n)
        begin
            next_r.rd_pend = 1'b1;
            next_r.rd_pend_addr = r.sync2.addr;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= DEV_RST;
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    assign link.read_value_out_o = r.q;
    assign link.read_value_out_oe = (r.rd_state != RD_OFF);
    assign write_commit = r.commit;
    assign read_launch = r.launch;
endmodule
`default_nettype wire

// ---- hdl/bq4_pkg.sv ----
// shared constants, pin bundle and state codes for the burst-of-four ddr sram link
package bq4_pkg;
    // 18-bit word configuration; the 36-bit one uses 36 / 17 / 4
    localparam int WORD_W = 18;
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int MASK_W = 2;
    localparam int BURST_LEN = 4;
    localparam int BEAT_W = 2;
    // flip-flop storage covers only the low burst addresses
    localparam int STORE_AW = 4;
    localparam int STORE_WORDS = BURST_LEN << STORE_AW;

    localparam int CLOCK_PERIOD_NS = 4;
    localparam int LINK_PERIOD_NS = 32;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / CLOCK_PERIOD_NS / 2;
    localparam int PHASE_W = 3;
    // host phase plan: pins change one clock before each input edge, read data sampled late
    localparam logic [PHASE_W-1:0] HOST_PREP_RISE_PHASE = PHASE_W'(2 * LINK_HALF_CYCLES - 2);
    localparam logic [PHASE_W-1:0] HOST_PREP_FALL_PHASE = PHASE_W'(LINK_HALF_CYCLES - 2);
    localparam logic [PHASE_W-1:0] HOST_CAPT_TRUE_PHASE = PHASE_W'(2 * LINK_HALF_CYCLES - 1);
    localparam logic [PHASE_W-1:0] HOST_CAPT_COMP_PHASE = PHASE_W'(LINK_HALF_CYCLES - 1);
    localparam logic [PHASE_W-1:0] HOST_FIRST_RISE_PHASE = 3'h0;

    // reset values
    localparam logic RST_SLOT_WR = 1'b0;
    localparam logic [PHASE_W-1:0] RST_HOST_PHASE = PHASE_W'(LINK_HALF_CYCLES);

    typedef struct packed {
        logic k;
        logic kc;
        logic c;
        logic cc;
        logic mode;
        logic rps_n;
        logic wps_n;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
        logic [MASK_W-1:0] mask_n;
    } bq4_pins_s;

    // idle pin levels: complements high, selects and masks off
    localparam bq4_pins_s RST_PINS = '{
        kc: 1'b1,
        cc: 1'b1,
        rps_n: 1'b1,
        wps_n: 1'b1,
        mask_n: '1,
        default: '0
    };
    localparam logic [3:0] RST_CLK_PREV = 4'h5;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_BURST = 2'b10
    } bq4_wr_e;

    typedef enum logic [2:0] {
        RD_OFF = 3'b001,
        RD_BURST = 3'b010,
        RD_TAIL = 3'b100
    } bq4_rd_e;
endpackage

// ---- hdl/bq4_link_if.sv ----
// pin-level link between memory controller and sram
`timescale 1ns/1ns
`default_nettype none
interface bq4_link_if;
    import bq4_pkg::*;
    logic input_timing_true;
    logic input_timing_comp;
    logic output_timing_true;
    logic output_timing_comp;
    logic single_clock_mode;
    logic [ADDR_W-1:0] shared_addr;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [WORD_W-1:0] write_value_in;
    logic [MASK_W-1:0] byte_lane_mask_n;
    logic [WORD_W-1:0] read_value_out_o;
    logic read_value_out_oe;
    wire [WORD_W-1:0] read_value_out;

    // released data reads as zero; the enable marks the undriven state
    assign read_value_out = read_value_out_oe ? read_value_out_o : {WORD_W{1'b0}};

    modport device_mp (
        input input_timing_true,
        input input_timing_comp,
        input output_timing_true,
        input output_timing_comp,
        input single_clock_mode,
        input shared_addr,
        input read_port_select_n,
        input write_port_select_n,
        input write_value_in,
        input byte_lane_mask_n,
        output read_value_out_o,
        output read_value_out_oe
    );

    modport host_mp (
        output input_timing_true,
        output input_timing_comp,
        output output_timing_true,
        output output_timing_comp,
        output single_clock_mode,
        output shared_addr,
        output read_port_select_n,
        output write_port_select_n,
        output write_value_in,
        output byte_lane_mask_n,
        input read_value_out,
        input read_value_out_oe
    );
endinterface
`default_nettype wire

// ---- hdl/bq4_sram_host.sv ----
// controller end: makes link clocks, issues bursts, collects read beats
`timescale 1ns/1ns
`default_nettype none
module bq4_sram_host
    import bq4_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // memory pins
    bq4_link_if.host_mp link,
    // configuration
    input wire logic single_clock_sel,
    // read request
    input wire logic rd_req,
    input wire logic [bq4_pkg::ADDR_W-1:0] rd_addr,
    output logic rd_ready,
    // write request
    input wire logic wr_req,
    input wire logic [bq4_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [bq4_pkg::BURST_LEN*bq4_pkg::WORD_W-1:0] wr_data,
    input wire logic [bq4_pkg::BURST_LEN*bq4_pkg::MASK_W-1:0] wr_mask_n,
    output logic wr_ready,
    // read data
    output logic rd_valid,
    output logic [bq4_pkg::WORD_W-1:0] rd_data,
    output logic rd_last
);
    import bq4_pkg::*;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic k;
        logic c;
        logic slot_wr;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_pend_addr;
        logic wr_pend;
        logic wr_busy;
        logic [BEAT_W-1:0] wr_beat;
        logic [ADDR_W-1:0] wr_pend_addr;
        logic [BURST_LEN*WORD_W-1:0] wr_pend_data;
        logic [BURST_LEN*MASK_W-1:0] wr_pend_mask;
        logic mode;
        logic rps_n;
        logic wps_n;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
        logic [MASK_W-1:0] mask_n;
        logic [WORD_W:0] sync1;
        logic [WORD_W:0] sync2;
        logic [BEAT_W-1:0] cap_beat;
        logic valid;
        logic last;
        logic [WORD_W-1:0] data;
    } bq4_host_s;

    localparam bq4_host_s HOST_RST = '{
        phase: RST_HOST_PHASE,
        slot_wr: RST_SLOT_WR,
        rps_n: 1'b1,
        wps_n: 1'b1,
        mask_n: '1,
        default: '0
    };

    bq4_host_s r;
    bq4_host_s next_r;

    assign rd_ready = ~r.rd_pend;
    assign wr_ready = ~r.wr_pend & ~r.wr_busy;

    always_comb
    begin
        next_r = r;
        next_r.phase = r.phase + 3'h1;
        next_r.k = (next_r.phase < PHASE_W'(LINK_HALF_CYCLES));
        next_r.mode = single_clock_sel;
        // output clocks parked in single-clock mode
        next_r.c = next_r.k & ~next_r.mode;
        next_r.sync1 = {link.read_value_out_oe, link.read_value_out};
        next_r.sync2 = r.sync1;
        next_r.valid = 1'b0;

        if (rd_req && !r.rd_pend)
        begin
            next_r.rd_pend = 1'b1;
            next_r.rd_pend_addr = rd_addr;
        end
        if (wr_req && !r.wr_pend && !r.wr_busy)
        begin
            next_r.wr_pend = 1'b1;
            next_r.wr_pend_addr = wr_addr;
            next_r.wr_pend_data = wr_data;
            next_r.wr_pend_mask = wr_mask_n;
        end

        if (r.phase == HOST_FIRST_RISE_PHASE)
        begin
            next_r.slot_wr = ~r.slot_wr;
        end

        // pins for the coming true input rise
        if (r.phase == HOST_PREP_RISE_PHASE)
        begin
            next_r.rps_n = 1'b1;
            next_r.wps_n = 1'b1;
            if (r.wr_busy)
            begin
                next_r.wdata = r.wr_pend_data[r.wr_beat*WORD_W +: WORD_W];
                next_r.mask_n = r.wr_pend_mask[r.wr_beat*MASK_W +: MASK_W];
                next_r.wr_beat = r.wr_beat + 2'h1;
            end
            else if (r.slot_wr && r.wr_pend)
            begin
                next_r.wps_n = 1'b0;
                next_r.addr = r.wr_pend_addr;
                next_r.wdata = r.wr_pend_data[WORD_W-1:0];
                next_r.mask_n = r.wr_pend_mask[MASK_W-1:0];
                next_r.wr_pend = 1'b0;
                next_r.wr_busy = 1'b1;
                next_r.wr_beat = 2'h1;
            end
            else if (!r.slot_wr && r.rd_pend)
            begin
                next_r.rps_n = 1'b0;
                next_r.addr = r.rd_pend_addr;
                next_r.rd_pend = 1'b0;
            end
        end

        // pins for the coming complementary input rise
        if (r.phase == HOST_PREP_FALL_PHASE)
        begin
            next_r.rps_n = 1'b1;
            next_r.wps_n = 1'b1;
            if (r.wr_busy)
            begin
                next_r.wdata = r.wr_pend_data[r.wr_beat*WORD_W +: WORD_W];
                next_r.mask_n = r.wr_pend_mask[r.wr_beat*MASK_W +: MASK_W];
                next_r.wr_beat = r.wr_beat + 2'h1;
                if (r.wr_beat == 2'h3)
                begin
                    next_r.wr_busy = 1'b0;
                end
            end
        end

        // read beats, sampled mid-way through their valid window
        if ((r.phase == HOST_CAPT_TRUE_PHASE || r.phase == HOST_CAPT_COMP_PHASE) && r.sync2[WORD_W])
        begin
            next_r.valid = 1'b1;
            next_r.data = r.sync2[WORD_W-1:0];
            next_r.last = (r.cap_beat == 2'h3);
            next_r.cap_beat = r.cap_beat + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= HOST_RST;
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    assign link.input_timing_true = r.k;
    assign link.input_timing_comp = ~r.k;
    assign link.output_timing_true = r.c;
    assign link.output_timing_comp = ~r.c;
    assign link.single_clock_mode = r.mode;
    assign link.shared_addr = r.addr;
    assign link.read_port_select_n = r.rps_n;
    assign link.write_port_select_n = r.wps_n;
    assign link.write_value_in = r.wdata;
    assign link.byte_lane_mask_n = r.mask_n;
    assign rd_valid = r.valid;
    assign rd_data = r.data;
    assign rd_last = r.last;
endmodule
`default_nettype wire

// ---- testbench/bq4_sram_checker.sv ----
// assertions on the link pins between controller and sram
`timescale 1ns/1ns
`default_nettype none
module bq4_sram_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link pins
    input wire logic input_timing_true,
    input wire logic input_timing_comp,
    input wire logic output_timing_true,
    input wire logic output_timing_comp,
    input wire logic [bq4_pkg::ADDR_W-1:0] shared_addr,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [bq4_pkg::WORD_W-1:0] write_value_in,
    input wire logic [bq4_pkg::MASK_W-1:0] byte_lane_mask_n,
    input wire logic read_value_out_oe
);
    import bq4_pkg::*;
    logic k_q;
    logic k_rise;
    logic slot_wr;
    logic [5:0] rd_age;
    assign k_rise = input_timing_true && !k_q;
    // slot tracker and age since the last selected read slot
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            k_q <= 1'b0;
            slot_wr <= RST_SLOT_WR;
            rd_age <= 6'h3f;
        end
        else
        begin
            k_q <= input_timing_true;
            if (k_rise)
                slot_wr <= ~slot_wr;
            if (k_rise && !slot_wr && !read_port_select_n)
                rd_age <= 6'h00;
            else if (rd_age != 6'h3f)
                rd_age <= rd_age + 6'h01;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    k_pair_a: assert property (input_timing_comp == !input_timing_true)
        else $error("input clock pair not complementary");
    c_pair_a: assert property (output_timing_comp == !output_timing_true)
        else $error("output clock pair not complementary");
    k_period_a: assert property (k_rise |-> input_timing_true [*4] ##1 !input_timing_true [*4] ##1 input_timing_true)
        else $error("input clock period wrong");
    sel_steady_a: assert property (k_rise |-> $stable(read_port_select_n) && $stable(write_port_select_n))
        else $error("port select moved at clock rise");
    addr_steady_a: assert property (k_rise |-> $stable(shared_addr))
        else $error("address moved at clock rise");
    wdata_steady_a: assert property ($changed(input_timing_true) |-> $stable(write_value_in) && $stable(byte_lane_mask_n))
        else $error("write beat or mask moved at clock edge");
    slot_alt_a: assert property (k_rise |-> (slot_wr ? read_port_select_n : write_port_select_n))
        else $error("select in the wrong slot");
    rd_start_a: assert property ($rose(read_value_out_oe) |-> rd_age >= 6'h06 && rd_age <= 6'h12)
        else $error("read output driven without a read");
    rd_burst_a: assert property ($rose(read_value_out_oe) |-> read_value_out_oe [*8] ##1 read_value_out_oe [*8])
        else $error("read burst shorter than four words");
    rd_release_a: assert property (rd_age > 6'h30 |-> !read_value_out_oe)
        else $error("read output not released");
endmodule
`default_nettype wire

// ---- testbench/bq4_sram_tb.sv ----
// self-checking bench: controller and sram joined by the link
`timescale 1ns/1ns
`default_nettype none
module bq4_sram_tb;
    import bq4_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic single_clock_sel = 1'b0;
    logic rd_req = 1'b0;
    logic [ADDR_W-1:0] rd_addr = '0;
    logic wr_req = 1'b0;
    logic [ADDR_W-1:0] wr_addr = '0;
    logic [BURST_LEN*WORD_W-1:0] wr_data = '0;
    logic [BURST_LEN*MASK_W-1:0] wr_mask_n = '1;
    logic rd_ready, wr_ready, rd_valid, rd_last, write_commit, read_launch;
    logic [WORD_W-1:0] rd_data;
    logic [WORD_W-1:0] model [0:STORE_WORDS-1];
    logic [7:0] masks [4] = '{8'h1b, 8'he4, 8'hff, 8'h66};
    int failures = 0;
    int n_compared = 0;
    int n_commit = 0;
    int n_launch = 0;
    bq4_link_if link ();
    wire [WORD_W-1:0] q_pin;
    assign q_pin = link.read_value_out_oe ? link.read_value_out_o : {WORD_W{1'bz}};
    bq4_sram_host u_bq4_sram_host (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .link(link),
        .single_clock_sel(single_clock_sel), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask_n(wr_mask_n), .wr_ready(wr_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last));
    bq4_sram_dev u_bq4_sram_dev (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .link(link),
        .write_commit(write_commit), .read_launch(read_launch));
    bq4_sram_checker u_bq4_sram_checker (.clock(clock), .rst_n(rst_n),
        .input_timing_true(link.input_timing_true), .input_timing_comp(link.input_timing_comp),
        .output_timing_true(link.output_timing_true), .output_timing_comp(link.output_timing_comp),
        .shared_addr(link.shared_addr), .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n), .write_value_in(link.write_value_in),
        .byte_lane_mask_n(link.byte_lane_mask_n), .read_value_out_oe(link.read_value_out_oe));
    always #2 clock = ~clock;
    // pulse counters, read at the falling edge while the pulse stands
    always @(negedge clock)
    begin
        if (write_commit === 1'b1)
            n_commit++;
        if (read_launch === 1'b1)
            n_launch++;
    end
    task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [BURST_LEN*WORD_W-1:0] d,
        input logic [BURST_LEN*MASK_W-1:0] m);
        int base;
        int t;
        base = n_commit;
        t = 0;
        while (wr_ready !== 1'b1 && t < 400)
        begin
            @(negedge clock);
            t++;
        end
        wr_addr = a;
        wr_data = d;
        wr_mask_n = m;
        wr_req = 1'b1;
        @(negedge clock);
        wr_req = 1'b0;
        check("wr_ready", WORD_W'(wr_ready), WORD_W'(0));
        // expected merge: unmasked lanes take the new beat
        for (int b = 0; b < BURST_LEN; b++)
            for (int l = 0; l < MASK_W; l++)
                if (!m[b*MASK_W+l])
                    model[{a[STORE_AW-1:0], BEAT_W'(b)}][l*LANE_W +: LANE_W] = d[b*WORD_W+l*LANE_W +: LANE_W];
        t = 0;
        while (n_commit == base && t < 400)
        begin
            @(negedge clock);
            t++;
        end
        check("write_commit", WORD_W'(n_commit - base), WORD_W'(1));
    endtask
    task automatic do_read(input logic [ADDR_W-1:0] a);
        int t;
        int lbase;
        t = 0;
        lbase = n_launch;
        while (rd_ready !== 1'b1 && t < 400)
        begin
            @(negedge clock);
            t++;
        end
        rd_addr = a;
        rd_req = 1'b1;
        @(negedge clock);
        rd_req = 1'b0;
        check("rd_ready", WORD_W'(rd_ready), WORD_W'(0));
        for (int b = 0; b < BURST_LEN; b++)
        begin
            t = 0;
            while (rd_valid !== 1'b1 && t < 200)
            begin
                @(negedge clock);
                t++;
            end
            check("rd_valid", WORD_W'(rd_valid), WORD_W'(1));
            check("rd_data", rd_data, model[{a[STORE_AW-1:0], BEAT_W'(b)}]);
            check("rd_last", WORD_W'(rd_last), WORD_W'(b == BURST_LEN - 1));
            @(negedge clock);
        end
        check("read_launch", WORD_W'(n_launch - lbase), WORD_W'(BURST_LEN));
    endtask
    task automatic s_idle();
        check("read_value_out", q_pin, {WORD_W{1'bz}});
        check("rd_ready", WORD_W'(rd_ready), WORD_W'(1));
    endtask
    task automatic s_full();
        do_read(18'h7);
        do_write(18'h3, {18'h3ffff, 18'h2aaaa, 18'h15555, 18'h00001}, 8'h00);
        do_read(18'h3);
    endtask
    task automatic s_masks();
        // lane masks per beat, including a fully masked burst
        for (int i = 0; i < 4; i++)
        begin
            do_write(18'h3, {WORD_W'(18'h3c3c3 - i), WORD_W'(18'h2b2b2 + i), WORD_W'(18'h1a1a1 ^ i),
                WORD_W'(18'h09090 + 2 * i)}, masks[i]);
            do_read(18'h3);
        end
    endtask
    task automatic s_single();
        single_clock_sel = 1'b1;
        repeat (8) @(negedge clock);
        do_read(18'h3);
        single_clock_sel = 1'b0;
        repeat (8) @(negedge clock);
    endtask
    task automatic s_concurrent();
        fork
            do_write(18'h5, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00);
            do_read(18'h3);
        join
        do_read(18'h5);
    endtask
    task automatic s_quiet();
        repeat (64) @(negedge clock);
        s_idle();
        do_read(18'h5);
        do_read(18'h3);
        repeat (40) @(negedge clock);
        s_idle();
    endtask
    initial
    begin
        #40000;
        failures++;
        report_and_stop();
    end
    initial
    begin
        for (int i = 0; i < STORE_WORDS; i++)
            model[i] = '0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        s_idle();
        s_full();
        s_masks();
        s_single();
        s_concurrent();
        s_quiet();
        report_and_stop();
    end
endmodule
`default_nettype wire
